// File: spi_master_model.sv
// serial master model that frames commands into the voice store
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic sys_clk_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      ss_b_o,
    output logic      mosi_o
);
    // link idle: clock low, select high
    initial begin
        sclk_o = 1'b0;
        ss_b_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one 16-bit frame, status returns while the command goes in
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] sts);
        // select low frames the whole command
        @(posedge sys_clk_i);
        #7 ss_b_o = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #13;
        // lsb first, address then control, status read back
        for (int i = 0; i < 16; i++) begin
            mosi_o = cmd[i];
            #24 sclk_o = 1'b1;
            sts[i] = miso_i;
            #24 sclk_o = 1'b0;
        end
        #24 ss_b_o = 1'b1;
        mosi_o = ~mosi_o; // released line shows no stale bit
        repeat (5) @(posedge sys_clk_i);
    endtask
endmodule // spi_master_model

// File: test_voice_store_spi_command_unit.sv
// self-checking bench for the voice store command unit
`timescale 1ns/1ps
module test_voice_store_spi_command_unit;
    logic       sys_clk_i, rst_b_i, sclk, ss_b, mosi, miso;
    logic       irq_o, powered_o, ready_o, playing_o, recording_o, skipping_o;
    logic [9:0] row_ptr_o;
    logic       m_pwr, m_eom, m_ovf;
    int         m_op, m_row, r, num_errors, checks;

    voice_store_spi_command_unit #(.PUD_CYCLES(20), .ROW_CYCLES(64), .SKIP_DIV(1600),
        .ROWS(600)) u_voice_store_spi_command_unit (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link_sclk_i(sclk), .ss_b_i(ss_b),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(), .irq_o(irq_o), .powered_o(powered_o),
        .ready_o(ready_o), .playing_o(playing_o), .recording_o(recording_o),
        .skipping_o(skipping_o), .row_ptr_o(row_ptr_o));
    spi_master_model u_master (.sys_clk_i(sys_clk_i), .miso_i(miso), .sclk_o(sclk),
        .ss_b_o(ss_b), .mosi_o(mosi));

    always #50 sys_clk_i = ~sys_clk_i;

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // state outputs against the model
    task automatic chk_st();
        logic [4:0] got, exp;
        got = {irq_o, powered_o, playing_o, recording_o, skipping_o};
        exp = {m_eom | m_ovf, m_pwr, m_op == 1, m_op == 2, m_op == 3};
        chk(16'(got), 16'(exp));
    endtask
    task automatic model_cmd(input logic [4:0] c, input int a);
        if (!c[2] && !c[4]) begin
            m_pwr = 1'b0;
            m_op = 0;
        end else if (!m_pwr) begin
            m_pwr = (c == 5'h04);
        end else if (!c[4]) begin
            m_op = 0;
        end else if (c[1] || a % 1024 < 600) begin
            m_op = c[0] ? 3 : (c[3] ? 1 : 2);
            m_row = c[1] ? m_row : a % 1024;
        end
    endtask
    // one frame through the master, then the model follows it
    task automatic send(input logic [4:0] c, input int a);
        logic [15:0] sts;
        u_master.xfer({c, 11'(a)}, sts);
        @(negedge sys_clk_i);
        chk({sts[15:12], 10'h0, sts[1:0]}, {14'h0, m_eom, m_ovf});
        m_eom = 1'b0;
        m_ovf = 1'b0;
        model_cmd(c, a);
        chk_st();
        if (c[4] && !c[1] && !c[0] && m_op != 0) chk(16'(row_ptr_o), 16'(m_row));
    endtask
    // bounded wait: 0 ready, 1 end of message, 2 overflow
    task automatic wait_evt(input int kind, input int lim);
        int n;
        n = 0;
        while ((kind != 0 ? irq_o : ready_o) !== 1'b1 && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            $display("[ERR] t=%0t wait expired irq %h ready %h", $time, irq_o, ready_o);
        end
        repeat (3) @(negedge sys_clk_i);
        if (kind == 1) m_eom = 1'b1;
        if (kind == 2) m_ovf = 1'b1;
        if (kind != 0) m_op = 0;
        chk_st();
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        sys_clk_i = 1'b0;
        rst_b_i = 1'b0;
        m_pwr = 1'b0;
        m_eom = 1'b0;
        m_ovf = 1'b0;
        void'($urandom(12812));
        r = $urandom_range(400, 100);
        repeat (3) @(posedge sys_clk_i);
        #7 rst_b_i = 1'b1;
        @(negedge sys_clk_i);
        chk_st();
        send(5'h1c, 100);
        send(5'h04, 0);
        chk(16'(ready_o), 16'h0);
        wait_evt(0, 40);
        send(5'h14, r);
        send(5'h0e, 0);
        send(5'h1c, r - 1);
        send(5'h1e, 0);
        wait_evt(1, 300);
        send(5'h06, 0);
        // skip chosen by the message bit, started from row r - 40
        send(5'h1d, r - 40);
        // a cleared ignore bit holds the skip on its start row; a set one carries it on
        send(5'h1f, 0);
        wait_evt(1, 200);
        chk(16'(row_ptr_o), 16'(r + 1));
        send(5'h1f, 0);
        wait_evt(2, 1000);
        send(5'h14, 598);
        send(5'h16, 0);
        wait_evt(2, 300);
        send(5'h1c, 600);
        send(5'h1c, 11'h405);
        send(5'h0b, 0);
        send(5'h1e, 0);
        tally_and_finish();
    end
    // watchdog against a hang
    initial begin
        #800000;
        num_errors++;
        tally_and_finish();
    end
endmodule // test_voice_store_spi_command_unit

// File: voice_store_pkg.sv
// types shared by the voice store serial command unit
package voice_store_pkg;
    // control field, c4 down to c0
    typedef struct packed {
        logic run;
        logic dir;
        logic pwr;
        logic ignore_address_bit;
        logic mc;
    } ctl_t;

    typedef struct packed {
        ctl_t        ctl;
        logic [10:0] addr;
    } frame_t;

    typedef struct packed {
        logic [3:0] pad;
        logic [9:0] row;
        logic       end_of_message_flag;
        logic       ovf;
    } status_t;

    typedef enum logic [3:0] {
        cmd_none         = 4'h0,
        wake_cmd         = 4'h1,
        play_at_addr_cmd = 4'h2,
        listen_here_cmd  = 4'h3,
        capture_at_addr_cmd = 4'h4,
        capture_here_cmd = 4'h5,
        skip_from_addr_cmd = 4'h6,
        skip_here_cmd    = 4'h7,
        halt_cmd         = 4'h8,
        halt_sleep_cmd   = 4'h9,
        stop_cmd         = 4'ha
    } cmd_t;

    typedef enum logic [2:0] {
        st_sleep  = 3'b000,
        st_waking = 3'b001,
        st_idle   = 3'b010,
        st_play   = 3'b011,
        st_rec    = 3'b100,
        st_skip   = 3'b101
    } op_state_t;
endpackage

// File: voice_store_props.sv
// port checks for the voice store command unit
`timescale 1ns/1ps
module voice_store_props #(
    parameter int unsigned PUD_CYCLES = 20,
    parameter int unsigned ROWS       = 600
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    input wire logic       ss_b_i,
    input wire logic       miso_oe_o,
    input wire logic       irq_o,
    input wire logic       powered_o,
    input wire logic       ready_o,
    input wire logic       playing_o,
    input wire logic       recording_o,
    input wire logic       skipping_o,
    input wire logic [9:0] row_ptr_o
);
    logic [31:0] up_cnt_r;
    logic        busy;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // cycles spent powered, restarts at every wake
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) up_cnt_r <= 32'h0;
        else up_cnt_r <= powered_o ? up_cnt_r + 32'h1 : 32'h0;
    end
    assign busy = playing_o | recording_o | skipping_o;
    // one check per documented relation
    a_oe_select: assert property (miso_oe_o == !ss_b_i)
        else $error("miso enable does not follow select");
    a_irq_frame_clear: assert property ($fell(ss_b_i) |-> ##[1:4] !irq_o)
        else $error("interrupt not cleared by frame start");
    a_start_after_select: assert property (
        ($rose(playing_o) || $rose(recording_o) || $rose(skipping_o))
        |-> ss_b_i && $past(ss_b_i, 3)) else $error("operation began inside a frame");
    a_one_op: assert property ($onehot0({playing_o, recording_o, skipping_o}))
        else $error("more than one operation active");
    a_op_ready: assert property (busy |-> ready_o && powered_o)
        else $error("operation while not ready");
    a_sleep_quiet: assert property (!powered_o |-> !ready_o && !busy)
        else $error("activity in standby");
    a_wake_early: assert property ($rose(ready_o) |-> up_cnt_r >= PUD_CYCLES - 1)
        else $error("ready before power-up delay");
    a_wake_late: assert property (powered_o && !ready_o |-> up_cnt_r <= PUD_CYCLES + 2)
        else $error("ready late after power-up delay");
    a_irq_ends_op: assert property ($rose(irq_o) |-> ##[0:2] !busy)
        else $error("operation kept running after interrupt");
    a_row_bound: assert property (32'(row_ptr_o) < ROWS)
        else $error("row pointer outside array");
    c_ready: cover property ($rose(ready_o));
    c_irq: cover property ($rose(irq_o));
    c_skip: cover property ($rose(skipping_o));
endmodule // voice_store_props

bind voice_store_spi_command_unit voice_store_props #(.PUD_CYCLES(PUD_CYCLES), .ROWS(ROWS))
    u_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ss_b_i(ss_b_i),
    .miso_oe_o(miso_oe_o), .irq_o(irq_o), .powered_o(powered_o), .ready_o(ready_o),
    .playing_o(playing_o), .recording_o(recording_o), .skipping_o(skipping_o),
    .row_ptr_o(row_ptr_o));

// File: voice_store_regs.svh
// constants for the voice store serial command unit
`ifndef VOICE_STORE_REGS_SVH
`define VOICE_STORE_REGS_SVH
`define VS_FRAME_BITS  16
`define VS_ADDR_BITS   11
`define VS_ROW_BITS    10
`define VS_ROWS        600
`define VS_CNT_BITS    5
`define VS_LAST_BIT    5'h0f
`define VS_SYS_MHZ     10
`define VS_PUD_US      25000
`define VS_ROW_US      200000
`define VS_SKIP_DIV    1600
`endif

// File: voice_store_spi_command_unit.sv
// serial command front end and operation sequencer of the voice store
`timescale 1ns/1ps
`include "voice_store_regs.svh"

module voice_store_spi_command_unit
    import voice_store_pkg::*;
#(
    parameter int unsigned PUD_CYCLES = `VS_PUD_US * `VS_SYS_MHZ,
    parameter int unsigned ROW_CYCLES = `VS_ROW_US * `VS_SYS_MHZ,
    parameter int unsigned SKIP_DIV   = `VS_SKIP_DIV,
    parameter int unsigned ROWS       = `VS_ROWS
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        link_sclk_i,
    input  wire logic        ss_b_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    output logic             irq_o,
    output logic             powered_o,
    output logic             ready_o,
    output logic             playing_o,
    output logic             recording_o,
    output logic             skipping_o,
    output logic [9:0]       row_ptr_o
);

    localparam int unsigned SKIP_RAW    = ROW_CYCLES / SKIP_DIV;
    localparam int unsigned SKIP_CYCLES = (SKIP_RAW > 0) ? SKIP_RAW : 1;
    localparam int unsigned LAST_ROW    = ROWS - 1;

    // ---------------- link domain (serial clock) ----------------
    logic                    link_rst_b;
    logic [`VS_CNT_BITS-1:0] rx_cnt_r;
    logic [`VS_CNT_BITS-1:0] tx_idx_r;
    logic [15:0]             rx_word_r;
    logic                    rx_done_r;

    // link counters are held clear while select is high
    assign link_rst_b = rst_b_i & ~ss_b_i;

    // frame begins on select low
    // bit counter restarts with every new selection
    always_ff @(posedge link_sclk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            rx_cnt_r <= '0;
        end else if (rx_cnt_r != `VS_FRAME_BITS) begin
            rx_cnt_r <= rx_cnt_r + 5'h01;
        end
    end

    // address low bits, control high bits
    always_ff @(posedge link_sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_word_r <= 16'h0000;
        end else if (!ss_b_i && rx_cnt_r < `VS_FRAME_BITS) begin
            rx_word_r[rx_cnt_r[3:0]] <= mosi_i;
        end
    end

    // completion flag: set by the last bit, cleared by the first of the next frame
    always_ff @(posedge link_sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_done_r <= 1'b0;
        end else if (!ss_b_i && rx_cnt_r == `VS_LAST_BIT) begin
            rx_done_r <= 1'b1;
        end else if (!ss_b_i && rx_cnt_r == '0) begin
            rx_done_r <= 1'b0;
        end
    end

    // status bit index advances on falling edges
    always_ff @(negedge link_sclk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            tx_idx_r <= '0;
        end else if (tx_idx_r != `VS_LAST_BIT) begin
            tx_idx_r <= tx_idx_r + 5'h01;
        end
    end

    // ---------------- system domain ----------------
    status_t   stat_frz_r;
    logic      ss_s1_r;
    logic      ss_s2_r;
    logic      ss_s3_r;
    logic      frame_start;
    logic      frame_end;
    cmd_t      cmd_r;
    logic      cmd_vld_r;
    frame_t    frame_r;
    op_state_t state_r;
    logic [9:0] row_r;
    logic [31:0] tmr_r;
    logic      rep_r;
    logic      eom_flag_r;
    logic      ovf_flag_r;
    logic      eom_evt;
    logic      ovf_evt;
    logic      mark_set;
    logic      mark_clr;
    logic      mark_r [0:ROWS-1];
    logic      row_end;
    logic      active;
    logic      addr_ok;

    // status shifts out while command shifts in
    // overflow and end flags lead the reply
    assign miso_o    = stat_frz_r[tx_idx_r[3:0]];
    assign miso_oe_o = ~ss_b_i;

    // select pin synchroniser plus edge stage
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ss_s1_r <= 1'b1;
            ss_s2_r <= 1'b1;
            ss_s3_r <= 1'b1;
        end else begin
            ss_s1_r <= ss_b_i;
            ss_s2_r <= ss_s1_r;
            ss_s3_r <= ss_s2_r;
        end
    end

    assign frame_start = ss_s3_r & ~ss_s2_r;
    assign frame_end   = ~ss_s3_r & ss_s2_r;

    // read-only status, frozen for the length of a frame
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_frz_r <= '0;
        end else if (ss_s2_r) begin
            stat_frz_r.pad <= 4'h0;
            stat_frz_r.row <= row_r;
            stat_frz_r.end_of_message_flag <= eom_flag_r;
            stat_frz_r.ovf <= ovf_flag_r;
        end
    end

    // command decode of the control field
    function automatic cmd_t decode(input ctl_t c);
        cmd_t r;
        r = cmd_none;
        // bit polarities of the control field
        if (!c.pwr) begin
            // standby request, message and direction bits free
            if (c.ignore_address_bit && !c.run) begin
                r = halt_sleep_cmd;
            end
        end else if (!c.run) begin
            if (c.ignore_address_bit && !c.mc) begin
                r = halt_cmd;
            end else if (!c.ignore_address_bit && !c.mc && !c.dir) begin
                r = wake_cmd;
            end else begin
                r = stop_cmd;
            end
        end else begin
            case ({c.mc, c.ignore_address_bit, c.dir})
                3'b001: r = play_at_addr_cmd;
                3'b011: r = listen_here_cmd;
                3'b000: r = capture_at_addr_cmd;
                3'b010: r = capture_here_cmd;
                3'b101: r = skip_from_addr_cmd;
                3'b111: r = skip_here_cmd;
                default: r = cmd_none;
            endcase
        end
        return r;
    endfunction

    // take the frame only once select is high again
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_r     <= cmd_none;
            cmd_vld_r <= 1'b0;
            frame_r   <= '0;
        end else begin
            cmd_vld_r <= frame_end & rx_done_r;
            if (frame_end && rx_done_r) begin
                frame_r <= frame_t'(rx_word_r);
                cmd_r   <= decode(ctl_t'(rx_word_r[15:`VS_ADDR_BITS]));
            end
        end
    end

    // ten low bits select a row, range checked
    // row must lie inside the array
    assign addr_ok = (32'(frame_r.addr[`VS_ROW_BITS-1:0]) < ROWS);
    assign active  = (state_r == st_play) || (state_r == st_rec) || (state_r == st_skip);
    assign row_end = active && (tmr_r == 32'h0000_0000);

    // operation sequencer: power, direction, row pointer, row timer
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= st_sleep;
            row_r   <= 10'h000;
            tmr_r   <= 32'h0000_0000;
            rep_r   <= 1'b0;
        end else if (cmd_vld_r && cmd_r == halt_sleep_cmd) begin
            state_r <= st_sleep;
        end else if (cmd_vld_r && state_r == st_sleep) begin
            if (cmd_r == wake_cmd) begin
                state_r <= st_waking;
                tmr_r   <= PUD_CYCLES;
            end
        end else if (state_r == st_waking) begin
            if (tmr_r == 32'h0000_0000) begin
                state_r <= st_idle;
            end else begin
                tmr_r <= tmr_r - 32'h0000_0001;
            end
        end else if (cmd_vld_r && frame_r.ctl.run && cmd_r != cmd_none) begin
            // cleared ignore bit reloads the start row and repeats it
            if (frame_r.ctl.ignore_address_bit || addr_ok) begin
                if (!frame_r.ctl.ignore_address_bit) begin
                    row_r <= frame_r.addr[`VS_ROW_BITS-1:0];
                end
                rep_r <= ~frame_r.ctl.ignore_address_bit;
                case (cmd_r)
                    // playback from start or current row
                    play_at_addr_cmd, listen_here_cmd: begin
                        state_r <= st_play;
                        tmr_r   <= ROW_CYCLES - 1;
                    end
                    // recording from start or current row
                    capture_at_addr_cmd, capture_here_cmd: begin
                        state_r <= st_rec;
                        tmr_r   <= ROW_CYCLES - 1;
                    end
                    // fast skip to the next marker
                    skip_from_addr_cmd, skip_here_cmd: begin
                        state_r <= st_skip;
                        tmr_r   <= SKIP_CYCLES - 1;
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end else if (cmd_vld_r && !frame_r.ctl.run) begin
            // run clear ends the operation, power kept
            state_r <= st_idle;
        end else if (row_end) begin
            if (state_r != st_rec && mark_r[row_r]) begin
                state_r <= st_idle;
                row_r   <= (32'(row_r) == LAST_ROW) ? 10'h000 : row_r + 10'h001;
            end else if (32'(row_r) == LAST_ROW && !rep_r) begin
                state_r <= st_idle;
            end else begin
                if (!rep_r) begin
                    row_r <= row_r + 10'h001;
                end
                tmr_r <= (state_r == st_skip) ? SKIP_CYCLES - 1 : ROW_CYCLES - 1;
            end
        end else if (active) begin
            tmr_r <= tmr_r - 32'h0000_0001;
        end
    end

    // leaving the last row overflows unless the row repeats or ends a message
    assign eom_evt  = row_end && state_r != st_rec && mark_r[row_r]
                      && !(cmd_vld_r && (cmd_r == halt_sleep_cmd || !frame_r.ctl.run));
    assign ovf_evt  = row_end && !eom_evt && 32'(row_r) == LAST_ROW && !rep_r
                      && !(cmd_vld_r && (cmd_r == halt_sleep_cmd || !frame_r.ctl.run));
    assign mark_set = (state_r == st_rec) && cmd_vld_r
                      && (!frame_r.ctl.run || cmd_r == halt_sleep_cmd);
    assign mark_clr = (state_r == st_rec) && row_end;

    // cleared at frame start, a same-cycle event wins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eom_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
        end else begin
            if (eom_evt) begin
                eom_flag_r <= 1'b1;
            end else if (frame_start) begin
                eom_flag_r <= 1'b0;
            end
            if (ovf_evt) begin
                ovf_flag_r <= 1'b1;
            end else if (frame_start) begin
                ovf_flag_r <= 1'b0;
            end
        end
    end

    // message marker per row: halt during record marks, recording over a row clears
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < ROWS; i++) begin
                mark_r[i] <= 1'b0;
            end
        end else if (mark_set) begin
            mark_r[row_r] <= 1'b1;
        end else if (mark_clr) begin
            mark_r[row_r] <= 1'b0;
        end
    end

    assign irq_o       = eom_flag_r | ovf_flag_r;
    assign powered_o   = (state_r != st_sleep);
    assign ready_o     = (state_r != st_sleep) && (state_r != st_waking);
    assign playing_o   = (state_r == st_play);
    assign recording_o = (state_r == st_rec);
    assign skipping_o  = (state_r == st_skip);
    assign row_ptr_o   = row_r;

endmodule // voice_store_spi_command_unit
